// [sipo_defs.svh]
// constants for the serial-in parallel-out sink driver
`ifndef SIPO_DEFS_SVH
`define SIPO_DEFS_SVH
`define SIPO_WIDTH       8
`define SIPO_RESET_DATA  8'h00
`define SIPO_SYNC_RESET  2'h0
`endif

// [sipo_pkg.sv]
// types shared by the sink driver files
`include "sipo_defs.svh"
package sipo_pkg;
   typedef logic [`SIPO_WIDTH-1:0] sipo_byte_t;
endpackage

// [sipo_sync.sv]
// two-flop synchroniser with edge detection for one pin
`timescale 1ns/1ps
module sipo_sync
   import sipo_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic pin_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   typedef struct packed {
      logic [1:0] sync;
      logic       prev;
   } sipo_sync_s;

   sipo_sync_s st_r;
   sipo_sync_s st_nxt;

   // first flop feeds only the second; edges seen after the second
   always_comb begin
      st_nxt      = st_r;
      st_nxt.sync = {st_r.sync[0], pin_in};
      st_nxt.prev = st_r.sync[1];
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level = st_r.sync[1];
   assign rise  = st_r.sync[1] & ~st_r.prev;
   assign fall  = ~st_r.sync[1] & st_r.prev;
endmodule // sipo_sync

// [sipo_driver.sv]
// serial-in parallel-out shift register with latch and sink outputs
// How it works
// R1: eight-bit shift register feeds an eight-bit latch stage in parallel.
// R2: shift_clock rising edge shifts in serial_in by one stage.
// R3: latch_clock rising edge copies all eight stages into the latch.
// R4: latch reaches the output buffers only while clear_n is high.
// R5: clear_n low clears shift register, latch and output buffers.
// R6: host should hold clear_n low during power-up.
// R7: output_enable_n high forces every output buffer bit low.
// R8: output_enable_n low lets buffers follow the latch with no clock.
// R9: sink output off when buffer bit low, sinking when high.
// R10: cascade_out updates from stage seven on shift_clock falling edge.
// R11: over-temperature forces outputs open until it clears.
// R12: host may pulse output_enable_n to dim all outputs together.
// R13: serial_in reaches cascade_out seven and a half shift periods later.
// R14: with enable low and clear high, outputs change at latch rise.
// R15: serial_in enters stage zero; stage n drives sink output n.
// R16: over-temperature is one input flag; registers keep their contents.
`timescale 1ns/1ps
`include "sipo_defs.svh"
module sipo_driver
   import sipo_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        shift_clock,
   input  wire logic        latch_clock,
   input  wire logic        serial_in,
   input  wire logic        clear_n,
   input  wire logic        output_enable_n,
   input  wire logic        over_temp,
   output logic             cascade_out,
   output logic [7:0]       sink_on,
   output logic [7:0]       sink_oe_n
);
   typedef struct packed {
      sipo_byte_t stages;
      sipo_byte_t latch;
      logic       casc;
      logic [1:0] sdat;
      logic [1:0] clr;
      logic [1:0] oen;
      logic [1:0] hot;
      sipo_byte_t buf_q;
   } sipo_drv_s;

   sipo_drv_s st_r;
   sipo_drv_s st_nxt;
   logic      sck_rise;
   logic      sck_fall;
   logic      lck_rise;

   // clock pins sampled and edge-detected on ref_clk
   sipo_sync u_sck (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  (shift_clock),
      .level   (),
      .rise    (sck_rise),
      .fall    (sck_fall)
   );

   sipo_sync u_lck (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  (latch_clock),
      .level   (),
      .rise    (lck_rise),
      .fall    ()
   );

   // data pins share the two-flop delay so they line up with clock edges
   always_comb begin
      st_nxt      = st_r;
      st_nxt.sdat = {st_r.sdat[0], serial_in};
      st_nxt.clr  = {st_r.clr[0], clear_n};
      st_nxt.oen  = {st_r.oen[0], output_enable_n};
      st_nxt.hot  = {st_r.hot[0], over_temp};
      if (!st_r.clr[1]) begin
         st_nxt.stages = `SIPO_RESET_DATA;                  // [R5]
         st_nxt.latch  = `SIPO_RESET_DATA;                  // [R5]
         st_nxt.casc   = 1'b0;
      end else begin
         if (sck_rise) begin
            st_nxt.stages = {st_r.stages[6:0], st_r.sdat[1]}; // [R2] [R15]
         end
         if (lck_rise) begin
            st_nxt.latch = st_r.stages;                     // [R1] [R3] [R14]
         end
         // falling edge gives half a period of hold downstream
         if (sck_fall) begin
            st_nxt.casc = st_r.stages[`SIPO_WIDTH-1];       // [R10] [R13]
         end
      end
      // buffers follow the latch; clear and disable force them low
      if (!st_r.clr[1] || st_r.oen[1]) begin
         st_nxt.buf_q = `SIPO_RESET_DATA;                   // [R4] [R5] [R7]
      end else begin
         st_nxt.buf_q = st_nxt.latch;                       // [R8] [R12]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // thermal gate masks outputs only; registers untouched
   assign cascade_out = st_r.casc;
   assign sink_on     = st_r.hot[1] ? 8'h00 : st_r.buf_q;   // [R11] [R16]
   assign sink_oe_n   = ~sink_on;                            // [R9]
endmodule // sipo_driver

// [sipo_driver_assertions.sv]
// port checks for the sink driver
`timescale 1ns/1ps
module sipo_chk (
   input logic       ref_clk,
   input logic       rst_n,
   input logic       shift_clock,
   input logic       latch_clock,
   input logic       clear_n,
   input logic       output_enable_n,
   input logic       over_temp,
   input logic       cascade_out,
   input logic [7:0] sink_on,
   input logic [7:0] sink_oe_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // enable and clear pins lag three flops, over_temp two, so those gates act three and two cycles late
   AST_INV: assert property (sink_oe_n == ~sink_on)
      else $error("inv");
   AST_OE: assert property (|sink_on |-> !$past(output_enable_n, 3))
      else $error("gate");
   AST_CLR: assert property (|sink_on |-> $past(clear_n, 3))
      else $error("clr");
   AST_HOT: assert property (|sink_on |-> !$past(over_temp, 2))
      else $error("hot");
   AST_CZ: assert property (!clear_n [*5] |-> !cascade_out)
      else $error("cz");
   AST_SZ: assert property (!clear_n [*4] |-> sink_on == 8'h00)
      else $error("sz");
   // pin seen at edge k reaches cascade_out in the sample at edge k+3
   AST_CAS: assert property (clear_n && $changed(cascade_out) |->
      $past(shift_clock, 4) && !$past(shift_clock, 3)) else $error("cas");
   AST_LT: assert property (
      (!output_enable_n && clear_n && !over_temp) [*6] ##1 $changed(sink_on)
      |-> $past(latch_clock, 3) && !$past(latch_clock, 4))
      else $error("lat");
endmodule // sipo_chk
bind sipo_driver sipo_chk sipo_chk_inst (.*);

// [sipo_host.sv]
// host model clocking bytes in
`timescale 1ns/1ps
module sipo_host (
   input  logic ref_clk,
   output logic shift_clock = 1'b0,
   output logic latch_clock = 1'b0,
   output logic serial_in = 1'b0
);
   // clocks idle low outside frames, 80 ns half period
   task frame(input logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         @(negedge ref_clk) serial_in = d[i];
         #80 shift_clock = 1'b1;
         #80 shift_clock = 1'b0;
      end
      #80 latch_clock = 1'b1;
      #80 latch_clock = 1'b0;
      serial_in = ~d[0]; // hold over, no stale bit
   endtask
endmodule // sipo_host

// [sipo_driver_test.sv]
// self-checking bench for the sink driver
`timescale 1ns/1ps
module sipo_driver_test;
   logic ref_clk = 1'b0, rst_n = 1'b0, clear_n = 1'b0, over_temp = 1'b0;
   logic output_enable_n = 1'b1, shift_clock, latch_clock, serial_in;
   logic cascade_out;
   logic [7:0] sink_on, sink_oe_n, d;
   int errors = 0, samples_checked = 0, seed = 32'h2a12;
   always #5 ref_clk = ~ref_clk;
   sipo_host sipo_host_inst (.*);
   sipo_driver sipo_driver_inst (.*);
   task chk(input logic [7:0] s, e);
      samples_checked++;
      if (s !== e) $display("unexpected %0t %h %h", $time, s, e);
      errors += s !== e;
   endtask
   task end_of_test();
      $display("%0d checks %0d bad", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // corner and random bytes through every gate mode, then clear
   initial begin
      repeat (20) @(negedge ref_clk);
      {rst_n, clear_n, output_enable_n} = 3'b110;
      for (int k = 0; k < 6; k++) begin
         d = k < 2 ? 8'h01 << 7 * k : 8'($random(seed));
         sipo_host_inst.frame(d);
         chk({7'h00, cascade_out}, {7'h00, d[7]});
         for (int m = 0; m < 5; m++) begin
            {over_temp, output_enable_n} = 2'(m % 4);
            repeat (6) @(negedge ref_clk);
            chk(sink_on, m % 4 ? 8'h00 : d);
            chk(sink_oe_n, m % 4 ? 8'hff : ~d);
         end
         $display("byte %0d done", k);
      end
      clear_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk(sink_on | {7'h00, cascade_out}, 8'h00);
      end_of_test();
   end
endmodule // sipo_driver_test
